// file: rtl/bmf_params.svh
// constants for the bus-matching dual fifo block
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH
`define BMF_LONG_W 36
`define BMF_WORD_W 18
`define BMF_LANE_W 9
`define BMF_FIFO_DEPTH 4
`define BMF_PART_ZERO 2'd0
`define BMF_PART_STEP 2'd1
`define BMF_LAST_WORD_PART 2'd1
`define BMF_LAST_BYTE_PART 2'd3
`define BMF_STRAP_COUNT 4
`define BMF_STRAP_ENDIAN 0
`define BMF_STRAP_FIRST_WORD_FALL_THROUGH 1
`define BMF_STRAP_WIDTH_B 2
`define BMF_STRAP_WIDTH_C 3
`define BMF_LONG_ZERO 36'h0
`define BMF_WORD_ZERO 18'h0
`define BMF_LANE_ZERO 9'h0
`endif

// file: rtl/bmf_pkg.sv
// types shared by the bus-matching dual fifo block
package bmf_pkg;
    typedef logic [35:0] long_word_type;
    typedef logic [17:0] port_word_type;
    typedef logic [1:0] part_index_type;
endpackage

// file: rtl/bmf_fifo.sv
// small synchronous fifo with valid/ready on both sides
module bmf_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // storage array, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // write pointer with wrap
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                AW'(wr_ptr_reg + 1'b1);
        end
    end

    // read pointer with wrap
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                AW'(rd_ptr_reg + 1'b1);
        end
    end

    // fill count
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// file: rtl/bus_match_fifo.sv
// bus-matching dual fifo: port a to b unpacker, port c to a packer
`include "bmf_params.svh"

// Behaviour
// - word writes pack two halves per endian
// - byte writes pack four lanes per endian
// - word reads give two halves per endian
// - byte reads give four lanes per endian
// - endian captured only during reset
// - byte reads drive upper lanes as zero
// - fall-through read side ready within three
// - late skew may add one cycle
// - read ready drops on final part only
// - standard read empty clears in two cycles
// - late skew may delay empty clear
// - read empty sets on final part only
// - fall-through return ready within three
// - late skew may add return cycle
// - return latency counts from completing write
// - standard return empty clears in two cycles
// - late return empty timed from completion
// - long word committed on completing write
// - read fifo whole words, parts held
module bus_match_fifo #(
    parameter int DEPTH = `BMF_FIFO_DEPTH
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_ENDIAN_ORDER_SELECT,
    input wire logic I_FIRST_WORD_FALL_THROUGH,
    input wire logic I_READ_SIDE_WIDTH_SELECT,
    input wire logic I_WRITE_SIDE_WIDTH_SELECT,
    input wire logic I_A_WR_VALID,
    input wire bmf_pkg::long_word_type I_A_WR_DATA,
    output logic O_A_WR_READY,
    input wire logic I_B_RD_REQ,
    output bmf_pkg::port_word_type O_B_RD_DATA,
    output logic O_READ_SIDE_OUTPUT_READY,
    output logic O_READ_SIDE_EMPTY_FLAG,
    input wire logic I_C_WR_VALID,
    input wire bmf_pkg::port_word_type I_C_WR_DATA,
    output logic O_C_WR_READY,
    input wire logic I_A_RD_REQ,
    output bmf_pkg::long_word_type O_A_RD_DATA,
    output logic O_RETURN_SIDE_OUTPUT_READY,
    output logic O_RETURN_SIDE_EMPTY_FLAG
);
    import bmf_pkg::*;

    logic [`BMF_STRAP_COUNT-1:0] strap_pins;
    logic [`BMF_STRAP_COUNT-1:0] strap_meta_reg;
    logic [`BMF_STRAP_COUNT-1:0] strap_sync_reg;
    logic endian_big_reg;
    logic first_word_fall_through_reg;
    logic byte_b;
    logic byte_c;

    // first fifo and read side unpacker
    logic f1_out_valid;
    logic f1_pop;
    long_word_type f1_out_data;
    long_word_type b_word_reg;
    logic b_have_reg;
    part_index_type b_part_reg;
    part_index_type b_last_part;
    logic b_or_reg;
    logic b_take;
    logic b_take_last;
    port_word_type b_data_reg;
    port_word_type b_part_data;

    // write side packer and second fifo
    part_index_type c_part_reg;
    part_index_type c_last_part;
    long_word_type c_acc_reg;
    long_word_type c_merged;
    logic c_is_last;
    logic c_write;
    logic f2_in_ready;
    logic f2_push;
    logic f2_out_valid;
    logic f2_pop;
    long_word_type f2_out_data;

    // return side output stage
    long_word_type a_word_reg;
    logic a_have_reg;
    logic a_or_reg;
    logic a_take;
    long_word_type a_data_reg;

    // maps a part number onto a lane, honouring byte order
    function automatic part_index_type lane_of(input logic big,
            input part_index_type last, input part_index_type part);
        lane_of = big ? part_index_type'(last - part) : part;
    endfunction

    assign strap_pins[`BMF_STRAP_ENDIAN] = I_ENDIAN_ORDER_SELECT;
    assign strap_pins[`BMF_STRAP_FIRST_WORD_FALL_THROUGH] = I_FIRST_WORD_FALL_THROUGH;
    assign strap_pins[`BMF_STRAP_WIDTH_B] = I_READ_SIDE_WIDTH_SELECT;
    assign strap_pins[`BMF_STRAP_WIDTH_C] = I_WRITE_SIDE_WIDTH_SELECT;

    // two-stage synchronisers for the strap pins
    generate
        for (genvar gi = 0; gi < `BMF_STRAP_COUNT; gi++) begin : g_sync
            always_ff @(posedge I_SYS_CLK) begin
                strap_meta_reg[gi] <= strap_pins[gi];
                strap_sync_reg[gi] <= strap_meta_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            endian_big_reg <= strap_sync_reg[`BMF_STRAP_ENDIAN];
            first_word_fall_through_reg <= strap_sync_reg[`BMF_STRAP_FIRST_WORD_FALL_THROUGH];
        end
    end

    assign byte_b = strap_sync_reg[`BMF_STRAP_WIDTH_B];
    assign byte_c = strap_sync_reg[`BMF_STRAP_WIDTH_C];

    bmf_fifo #(
        .WIDTH(`BMF_LONG_W),
        .DEPTH(DEPTH)
    ) u_fifo_one (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_in_valid(I_A_WR_VALID),
        .o_in_ready(O_A_WR_READY),
        .i_in_data(I_A_WR_DATA),
        .o_out_valid(f1_out_valid),
        .i_out_ready(f1_pop),
        .o_out_data(f1_out_data)
    );

    // read side part selection and step control
    assign b_last_part = byte_b ? `BMF_LAST_BYTE_PART : `BMF_LAST_WORD_PART;
    assign b_take = b_have_reg &&
        (first_word_fall_through_reg ? (!b_or_reg || I_B_RD_REQ) : I_B_RD_REQ);
    assign b_take_last = b_take && (b_part_reg == b_last_part);
    // fetch next long word when current one is spent
    assign f1_pop = !b_have_reg || b_take_last;

    // lane extraction per width and order
    always_comb begin
        b_part_data = `BMF_WORD_ZERO;
        if (byte_b) begin
            b_part_data = {`BMF_LANE_ZERO, b_word_reg[
                lane_of(endian_big_reg, b_last_part, b_part_reg)
                * `BMF_LANE_W +: `BMF_LANE_W]};
        end else begin
            b_part_data = b_word_reg[
                lane_of(endian_big_reg, b_last_part, b_part_reg)
                * `BMF_WORD_W +: `BMF_WORD_W];
        end
    end

    // held long word and its presence
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            b_have_reg <= 1'b0;
            b_word_reg <= `BMF_LONG_ZERO;
        end else if (f1_pop) begin
            b_have_reg <= f1_out_valid;
            b_word_reg <= f1_out_data;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            b_part_reg <= `BMF_PART_ZERO;
        end else if (f1_pop) begin
            b_part_reg <= `BMF_PART_ZERO;
        end else if (b_take) begin
            b_part_reg <= b_part_reg + `BMF_PART_STEP;
        end
    end

    // read side output register
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            b_data_reg <= `BMF_WORD_ZERO;
        end else if (b_take) begin
            b_data_reg <= b_part_data;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || !first_word_fall_through_reg) begin
            b_or_reg <= 1'b0;
        end else if (b_take) begin
            b_or_reg <= 1'b1;
        end else if (I_B_RD_REQ) begin
            b_or_reg <= 1'b0;
        end
    end

    assign O_READ_SIDE_EMPTY_FLAG = first_word_fall_through_reg ? !b_or_reg : !b_have_reg;
    assign O_READ_SIDE_OUTPUT_READY = b_or_reg;
    assign O_B_RD_DATA = b_data_reg;

    // write side completion and back-pressure
    assign c_last_part = byte_c ? `BMF_LAST_BYTE_PART : `BMF_LAST_WORD_PART;
    assign c_is_last = (c_part_reg == c_last_part);
    assign O_C_WR_READY = !c_is_last || f2_in_ready;
    assign c_write = I_C_WR_VALID && O_C_WR_READY;
    assign f2_push = c_write && c_is_last;

    // lane insertion per width and order
    always_comb begin
        c_merged = c_acc_reg;
        if (byte_c) begin
            c_merged[lane_of(endian_big_reg, c_last_part, c_part_reg)
                * `BMF_LANE_W +: `BMF_LANE_W] =
                I_C_WR_DATA[`BMF_LANE_W-1:0];
        end else begin
            c_merged[lane_of(endian_big_reg, c_last_part, c_part_reg)
                * `BMF_WORD_W +: `BMF_WORD_W] = I_C_WR_DATA;
        end
    end

    // earlier parts kept in the accumulator
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            c_acc_reg <= `BMF_LONG_ZERO;
        end else if (c_write) begin
            c_acc_reg <= c_merged;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            c_part_reg <= `BMF_PART_ZERO;
        end else if (c_write) begin
            c_part_reg <= c_is_last ? `BMF_PART_ZERO :
                c_part_reg + `BMF_PART_STEP;
        end
    end

    bmf_fifo #(
        .WIDTH(`BMF_LONG_W),
        .DEPTH(DEPTH)
    ) u_fifo_two (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_in_valid(f2_push),
        .o_in_ready(f2_in_ready),
        .i_in_data(c_merged),
        .o_out_valid(f2_out_valid),
        .i_out_ready(f2_pop),
        .o_out_data(f2_out_data)
    );

    // return side step control
    assign a_take = a_have_reg &&
        (first_word_fall_through_reg ? (!a_or_reg || I_A_RD_REQ) : I_A_RD_REQ);
    assign f2_pop = !a_have_reg || a_take;

    // held word loaded from the committed long word
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            a_have_reg <= 1'b0;
            a_word_reg <= `BMF_LONG_ZERO;
        end else if (f2_pop) begin
            a_have_reg <= f2_out_valid;
            a_word_reg <= f2_out_data;
        end
    end

    // return side output register
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            a_data_reg <= `BMF_LONG_ZERO;
        end else if (a_take) begin
            a_data_reg <= a_word_reg;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || !first_word_fall_through_reg) begin
            a_or_reg <= 1'b0;
        end else if (a_take) begin
            a_or_reg <= 1'b1;
        end else if (I_A_RD_REQ) begin
            a_or_reg <= 1'b0;
        end
    end

    // return empty, two cycles after completion in standard mode, three in fall-through
    assign O_RETURN_SIDE_EMPTY_FLAG = first_word_fall_through_reg ? !a_or_reg : !a_have_reg;
    assign O_RETURN_SIDE_OUTPUT_READY = a_or_reg;
    assign O_A_RD_DATA = a_data_reg;
endmodule

// file: tb/bmf_host_model.sv
// host-side model that owns the width and mode straps
module bmf_host_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_want,
    output logic o_first_word_fall_through,
    output logic o_width_b,
    output logic o_width_c
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            {o_first_word_fall_through, o_width_b, o_width_c} <= i_want;
        end
    end
endmodule

// file: tb/bmf_checker_sva.sv
// port assertions for the bus-matching dual fifo
module bmf_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_FIRST_WORD_FALL_THROUGH,
    input wire logic I_READ_SIDE_WIDTH_SELECT,
    input wire logic I_WRITE_SIDE_WIDTH_SELECT,
    input wire logic I_A_WR_VALID,
    input wire logic O_A_WR_READY,
    input wire logic I_B_RD_REQ,
    input wire bmf_pkg::port_word_type O_B_RD_DATA,
    input wire logic O_READ_SIDE_OUTPUT_READY,
    input wire logic O_READ_SIDE_EMPTY_FLAG,
    input wire logic I_C_WR_VALID,
    input wire logic O_C_WR_READY,
    input wire logic O_RETURN_SIDE_OUTPUT_READY,
    input wire logic O_RETURN_SIDE_EMPTY_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    import bmf_pkg::*;
    logic [1:0] part_reg;
    logic done;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    // write that completes a long word on port c
    assign done = I_C_WR_VALID && O_C_WR_READY
        && part_reg == (I_WRITE_SIDE_WIDTH_SELECT ? 2'h3 : 2'h1);
    // part counter of port c writes
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            part_reg <= 2'h0;
        end else if (I_C_WR_VALID && O_C_WR_READY) begin
            part_reg <= done ? 2'h0 : part_reg + 2'h1;
        end
    end
    sequence a_take_s;
        I_A_WR_VALID && O_A_WR_READY;
    endsequence
    a_fill_ready_b: assert property (
        (I_FIRST_WORD_FALL_THROUGH && O_READ_SIDE_EMPTY_FLAG) ##0 a_take_s
        |-> ##[1:3] O_READ_SIDE_OUTPUT_READY) else $error("read ready late");
    a_empty_clear_b: assert property (
        (!I_FIRST_WORD_FALL_THROUGH && O_READ_SIDE_EMPTY_FLAG) ##0 a_take_s
        |-> ##[1:2] !O_READ_SIDE_EMPTY_FLAG) else $error("read empty late");
    a_ready_drop_b: assert property (
        $fell(O_READ_SIDE_OUTPUT_READY) |-> $past(I_B_RD_REQ))
        else $error("ready fell without read");
    a_empty_set_b: assert property (
        $rose(O_READ_SIDE_EMPTY_FLAG) |-> $past(I_B_RD_REQ))
        else $error("empty rose without read");
    a_data_hold_b: assert property (
        O_READ_SIDE_OUTPUT_READY && !I_B_RD_REQ |=> $stable(O_B_RD_DATA))
        else $error("data moved");
    a_byte_upper_zero: assert property (
        I_READ_SIDE_WIDTH_SELECT && $past(I_READ_SIDE_WIDTH_SELECT, 3)
        |-> O_B_RD_DATA[17:9] == 9'h0) else $error("upper lanes not zero");
    a_fill_ready_a: assert property (
        I_FIRST_WORD_FALL_THROUGH && O_RETURN_SIDE_EMPTY_FLAG && done
        |-> ##[1:3] O_RETURN_SIDE_OUTPUT_READY)
        else $error("return ready late");
    a_empty_clear_a: assert property (
        !I_FIRST_WORD_FALL_THROUGH && O_RETURN_SIDE_EMPTY_FLAG && done
        |-> ##[1:2] !O_RETURN_SIDE_EMPTY_FLAG)
        else $error("return empty late");
    a_commit_on_done: assert property (
        $fell(O_RETURN_SIDE_EMPTY_FLAG) |-> $past(done, 2) || $past(done, 3))
        else $error("early commit");
endmodule
bind bus_match_fifo bmf_checker chk (.I_SYS_CLK, .I_RST_N,
    .I_FIRST_WORD_FALL_THROUGH, .I_READ_SIDE_WIDTH_SELECT,
    .I_WRITE_SIDE_WIDTH_SELECT, .I_A_WR_VALID, .O_A_WR_READY, .I_B_RD_REQ,
    .O_B_RD_DATA, .O_READ_SIDE_OUTPUT_READY, .O_READ_SIDE_EMPTY_FLAG,
    .I_C_WR_VALID, .O_C_WR_READY, .O_RETURN_SIDE_OUTPUT_READY,
    .O_RETURN_SIDE_EMPTY_FLAG);

// file: tb/testbench.sv
// self-checking bench for the bus-matching dual fifo
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import bmf_pkg::*;
    logic clk, rst_n, endian, big, a_vld, b_req, c_vld, a_req;
    logic [2:0] want;
    logic [31:0] seed = 32'h1f;
    long_word_type a_data, a_rdata, cw;
    port_word_type c_data, b_data;
    wire first_word_fall_through, wb, wc, a_rdy, c_rdy, b_ordy, b_emp, a_ordy, a_emp;
    int miscompares, check_count;
    long_word_type q[$];
    bmf_host_model host (.i_clk(clk), .i_rst_n(rst_n), .i_want(want),
        .o_first_word_fall_through(first_word_fall_through), .o_width_b(wb), .o_width_c(wc));
    bus_match_fifo #(.DEPTH(4)) DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n),
        .I_ENDIAN_ORDER_SELECT(endian), .I_FIRST_WORD_FALL_THROUGH(first_word_fall_through),
        .I_READ_SIDE_WIDTH_SELECT(wb), .I_WRITE_SIDE_WIDTH_SELECT(wc),
        .I_A_WR_VALID(a_vld), .I_A_WR_DATA(a_data), .O_A_WR_READY(a_rdy),
        .I_B_RD_REQ(b_req), .O_B_RD_DATA(b_data),
        .O_READ_SIDE_OUTPUT_READY(b_ordy), .O_READ_SIDE_EMPTY_FLAG(b_emp),
        .I_C_WR_VALID(c_vld), .I_C_WR_DATA(c_data), .O_C_WR_READY(c_rdy),
        .I_A_RD_REQ(a_req), .O_A_RD_DATA(a_rdata),
        .O_RETURN_SIDE_OUTPUT_READY(a_ordy), .O_RETURN_SIDE_EMPTY_FLAG(a_emp));
    // free-running 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // slice i of a long word in transfer order
    function automatic long_word_type part(long_word_type w, logic by, int i);
        int u;
        int p;
        u = by ? 9 : 18;
        p = big ? (by ? 3 : 1) - i : i;
        return (w >> (p * u)) & ((36'h1 << u) - 36'h1);
    endfunction
    function automatic logic avail(int s);
        case (s)
            0: return a_rdy;
            1: return c_rdy;
            2: return first_word_fall_through ? b_ordy : !b_emp;
            default: return first_word_fall_through ? a_ordy : !a_emp;
        endcase
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(long_word_type got, long_word_type exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #10;
    endtask
    // bounded wait for a side to be available
    task automatic wait_on(int s);
        int n;
        n = 0;
        while (avail(s) !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        if (avail(s) !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic wr(logic side_c, long_word_type w);
        if (side_c) {c_vld, c_data} = {1'b1, port_word_type'(w)};
        else {a_vld, a_data} = {1'b1, w};
        wait_on(side_c ? 1 : 0);
        tick();
        {a_vld, c_vld} = 2'h0;
        tick();
    endtask
    task automatic rd(logic side_a, long_word_type exp, logic last);
        wait_on(side_a ? 3 : 2);
        if (first_word_fall_through) check(side_a ? a_rdata : b_data, exp);
        if (side_a) a_req = 1'b1;
        else b_req = 1'b1;
        tick();
        {a_req, b_req} = 2'h0;
        if (!first_word_fall_through) check(side_a ? a_rdata : b_data, exp);
        check(long_word_type'(side_a ? a_emp : b_emp), last);
        tick();
    endtask
    // all sixteen mode combinations, each after a fresh reset
    initial begin
        {rst_n, endian, big, a_vld, b_req, c_vld, a_req} = 7'h0;
        {a_data, c_data, want} = 57'h0;
        miscompares = 0;
        check_count = 0;
        for (int m = 0; m < 16; m++) begin
            {big, want} = m[3:0];
            endian = big;
            rst_n = 1'b0;
            repeat (10) tick();
            rst_n = 1'b1;
            endian = ~big;
            check(long_word_type'({b_emp, a_emp, a_rdy, c_rdy}),
                36'hf);
            q.delete();
            while (a_rdy === 1'b1 && q.size() < 8) begin
                q.push_back(long_word_type'({rnd(), rnd()}));
                wr(1'b0, q[$]);
            end
            check(long_word_type'(a_rdy), 36'h0);
            {a_vld, a_data} = {1'b1, long_word_type'({rnd(), rnd()})};
            tick();
            a_vld = 1'b0;
            foreach (q[k]) for (int i = 0; i < (wb ? 4 : 2); i++)
                rd(0, part(q[k], wb, i),
                    k == q.size() - 1 && i == (wb ? 3 : 1));
            q.delete();
            // pack long words on port c until fifo two pushes back
            while (c_rdy === 1'b1 && q.size() < 8) begin
                cw = long_word_type'({rnd(), rnd()});
                for (int i = 0; i < (wc ? 4 : 2) && c_rdy === 1'b1; i++)
                    wr(1'b1, part(cw, wc, i) |
                        (wc ? rnd() & 36'h3fe00 : 36'h0));
                if (c_rdy === 1'b1) q.push_back(cw);
            end
            check(long_word_type'(c_rdy), 36'h0);
            // completing part offered while full must be ignored
            {c_vld, c_data} = {1'b1, port_word_type'(rnd())};
            tick();
            c_vld = 1'b0;
            foreach (q[k]) rd(1, q[k], k == q.size() - 1);
        end
        final_report();
    end
endmodule
